/* File: hw/cfc_defs.svh */
// cfc_defs.svh: constants of the fault confinement block.
// assumes: included by bare name in the design files; the testbench files repeat the numbers as literals.
`ifndef CFC_DEFS_SVH
`define CFC_DEFS_SVH
`define CFC_TALLY_W      8
`define CFC_SYNC_BITS    11
`define CFC_OFF_SEQS     128
`define CFC_WARN_LEVEL   96
`define CFC_PASSIVE_LVL  128
`define CFC_STEP_BIG     8
`define CFC_STEP_ONE     1
`define CFC_DOM_ACTIVE   14
`define CFC_DOM_PASSIVE  8
`define CFC_DOM_AGAIN    8
`define CFC_RX_MSB       7
`endif

/* File: hw/cfc_pkg.sv */
// cfc_pkg.sv: types of the fault confinement block.
// assumes: nothing beyond a SystemVerilog compiler.
package cfc_pkg;
	typedef enum logic [2:0] {
		CFC_SYNC,
		CFC_ACTIVE,
		CFC_WARNING,
		CFC_PASSIVE,
		CFC_BUSOFF
	} cfc_state_type;
	typedef logic [7:0] cfc_tally_type;
endpackage

/* File: hw/cfc_run_if.sv */
// cfc_run_if.sv: carries a recessive run count request and result.
// assumes: one clock, both ends in the same domain.
`timescale 1ns/1ps
`default_nettype none
interface cfc_run_if;
	logic bitTick;   // one sampled bus bit
	logic recessive; // level of that bit
	logic clear;     // restart the run count
	logic runDone;   // eleven recessive bits seen
	modport owner (output bitTick, output recessive, output clear, input runDone);
	modport counter (input bitTick, input recessive, input clear, output runDone);
endinterface
`default_nettype wire

/* File: hw/cfc_run_counter.sv */
// cfc_run_counter.sv: counts consecutive recessive bits, pulses on the eleventh.
// assumes: bitTick is a one-cycle enable per bus bit.
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defs.svh"
module cfc_run_counter #(
	parameter int RUN_BITS = `CFC_SYNC_BITS
) (
	input  wire logic clk,  // bit logic clock
	input  wire logic rstn, // async reset, active low
	cfc_run_if.counter run  // run request and result
);
	logic [4:0] runCnt_ff;
	logic [4:0] nxt_runCnt;
	logic       runDone_ff;
	logic       hit;
	// a dominant bit restarts the run; count restarts after each full run
	assign hit = run.bitTick && run.recessive && (runCnt_ff == 5'(RUN_BITS - 1));
	assign nxt_runCnt = (run.clear || (run.bitTick && !run.recessive) || hit) ? 5'h00 :
	                    run.bitTick ? runCnt_ff + 5'h01 : runCnt_ff;
	assign run.runDone = runDone_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			runCnt_ff  <= 5'h00;
			runDone_ff <= 1'b0;
		end else begin
			runCnt_ff  <= nxt_runCnt;
			runDone_ff <= hit && !run.clear;
		end
	end
endmodule
`default_nettype wire

/* File: hw/cfc_fault_confinement.sv */
// cfc_fault_confinement.sv: error tallies and node state of a CAN controller.
// assumes: error detection supplies one-cycle event pulses, bitTick per bus bit.
`timescale 1ns/1ps
`default_nettype none
`include "cfc_defs.svh"
module cfc_fault_confinement #(
	parameter int SYNC_BITS = `CFC_SYNC_BITS,
	parameter int OFF_SEQS  = `CFC_OFF_SEQS
) (
	input  wire logic              clk,           // bit logic clock, 100 MHz
	input  wire logic              rstn,          // async reset, active low
	input  wire logic              enable,        // module enable
	input  wire logic              wakeUp,        // wake-up pulse
	input  wire logic              bitTick,       // one pulse per sampled bus bit
	input  wire logic              rxBit,         // sampled bus level, 1 recessive
	input  wire logic              rxFlagBitErr,  // receiver bit error in active flag
	input  wire logic              rxDomAfterFlag,// dominant first bit after own flag
	input  wire logic              rxOtherErr,    // receiver stuff/form/crc/ack error
	input  wire logic              txFlagBitErr,  // transmitter bit error in active flag
	input  wire logic              txOtherErr,    // transmitter stuff/form/crc/ack error
	input  wire logic              txArbStuffErr, // stuff error was in arbitration
	input  wire logic              txAckErr,      // transmitter error was ack error
	input  wire logic              domInPassFlag, // dominant seen during passive flag
	input  wire logic              domRunAfterFlag,// dominant run after flag, count step
	input  wire logic              flagWasPassive,// that flag was passive
	input  wire logic              isTransmitter, // node is transmitting this frame
	input  wire logic              rxValid,       // valid reception pulse
	input  wire logic              txValid,       // valid transmission pulse
	output cfc_pkg::cfc_state_type nodeState,     // confinement state
	output logic                   busOn,         // node may take part in traffic
	output logic                   driverEn,      // bus output driver enable
	output logic                   dominantFlag,  // error flags are dominant
	output logic [15:0]            fault_tally_register // transmit:receive tallies
);
	import cfc_pkg::*;
	cfc_state_type state_ff;
	cfc_state_type nxt_state;
	cfc_tally_type receive_fault_tally_ff;
	cfc_tally_type transmit_fault_tally_ff;
	logic [8:0]    nxt_rx;
	logic [8:0]    nxt_tx;
	logic [7:0]    seqCnt_ff;
	logic [7:0]    nxt_seqCnt;
	logic [4:0]    domCnt_ff;
	logic [4:0]    nxt_domCnt;
	logic          domAgain_ff;
	logic          domStep;
	logic          enable_ff;
	logic          enRise;
	logic          resync;
	logic          inSync;
	logic          inOff;
	logic          rxAdd8;
	logic          rxAdd1;
	logic          txAdd8;
	logic          rxSat;
	logic          passiveNow;
	logic          activeNow;
	logic          warnNow;
	logic          offEnd;
	cfc_run_if     run ();

	cfc_run_counter #(.RUN_BITS(SYNC_BITS)) u_run (
		.clk  (clk),
		.rstn (rstn),
		.run  (run)
	);

	// run counter is shared by the sync wait and the bus off recovery
	assign enRise        = enable && !enable_ff;
	assign resync        = enRise || wakeUp;
	assign inSync        = (state_ff == CFC_SYNC);
	assign inOff         = (state_ff == CFC_BUSOFF);
	assign run.bitTick   = bitTick && enable;
	assign run.recessive = rxBit;
	assign run.clear     = resync || !(inSync || inOff);

	// dominant runs after a flag: 14 after active, 8 after passive, then every 8 more
	assign nxt_domCnt = !domRunAfterFlag ? 5'h00 :
	                    (bitTick && !rxBit) ? (domStep ? 5'h00 : domCnt_ff + 5'h01) : domCnt_ff;
	assign domStep = domRunAfterFlag && bitTick && !rxBit &&
	                 (domCnt_ff == (domAgain_ff ? 5'(`CFC_DOM_AGAIN - 1) :
	                  flagWasPassive ? 5'(`CFC_DOM_PASSIVE - 1) : 5'(`CFC_DOM_ACTIVE - 1)));

	// increment causes; bus off means no activity, so nothing counts there
	assign rxSat  = receive_fault_tally_ff[`CFC_RX_MSB];
	assign rxAdd8 = !isTransmitter && (rxFlagBitErr || rxDomAfterFlag || domStep);
	assign rxAdd1 = !isTransmitter && rxOtherErr;
	assign txAdd8 = isTransmitter && (txFlagBitErr || domStep ||
	                (txOtherErr && !txArbStuffErr &&
	                 !(txAckErr && passiveNow && !domInPassFlag)));

	// receive tally: saturates once bit 7 set, decrement on valid frame
	always_comb begin
		nxt_rx = {1'b0, receive_fault_tally_ff};
		if (inOff || inSync) begin
			nxt_rx = nxt_rx;
		end else if ((rxAdd8 || rxAdd1) && !rxSat) begin
			nxt_rx = nxt_rx + (rxAdd8 ? 9'(`CFC_STEP_BIG) : 9'(`CFC_STEP_ONE));
			if (nxt_rx[8]) begin
				nxt_rx = 9'h0ff;
			end
		end else if (rxValid && receive_fault_tally_ff != 8'h00) begin
			nxt_rx = nxt_rx - 9'h001;
		end
		if (offEnd) begin
			nxt_rx = 9'h000;
		end
	end

	// transmit tally: a carry out of bit 7 is the step past 255
	always_comb begin
		nxt_tx = {1'b0, transmit_fault_tally_ff};
		if (inOff || inSync) begin
			nxt_tx = nxt_tx;
		end else if (txAdd8) begin
			nxt_tx = nxt_tx + 9'(`CFC_STEP_BIG);
		end else if (txValid && transmit_fault_tally_ff != 8'h00) begin
			nxt_tx = nxt_tx - 9'h001;
		end
		if (offEnd) begin
			nxt_tx = 9'h000;
		end
	end

	// state from the tallies that are being written this cycle
	assign passiveNow = (state_ff == CFC_PASSIVE);
	assign activeNow  = (nxt_tx < 9'(`CFC_PASSIVE_LVL)) && (nxt_rx < 9'(`CFC_PASSIVE_LVL));
	assign warnNow    = (nxt_tx >= 9'(`CFC_WARN_LEVEL)) || (nxt_rx >= 9'(`CFC_WARN_LEVEL));
	assign offEnd     = inOff && run.runDone && (seqCnt_ff == 8'(OFF_SEQS - 1));
	assign nxt_seqCnt = !inOff ? 8'h00 : (run.runDone ? seqCnt_ff + 8'h01 : seqCnt_ff);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			CFC_SYNC: begin
				if (run.runDone && !resync) begin
					// tallies kept over a wake-up still decide the level that is rejoined
					nxt_state = !activeNow ? CFC_PASSIVE : (warnNow ? CFC_WARNING : CFC_ACTIVE);
				end
			end
			CFC_BUSOFF: begin
				if (offEnd) begin
					nxt_state = CFC_ACTIVE;
				end
			end
			CFC_ACTIVE, CFC_WARNING, CFC_PASSIVE: begin
				if (nxt_tx[8]) begin
					nxt_state = CFC_BUSOFF;
				end else if (!activeNow) begin
					nxt_state = CFC_PASSIVE;
				end else if (warnNow) begin
					nxt_state = CFC_WARNING;
				end else begin
					nxt_state = CFC_ACTIVE;
				end
			end
			default: begin
				nxt_state = CFC_SYNC;
			end
		endcase
		if (resync || !enable) begin
			nxt_state = CFC_SYNC;
		end
	end

	// keep state and tallies apart from the small helper flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff                <= CFC_SYNC;
			receive_fault_tally_ff  <= 8'h00;
			transmit_fault_tally_ff <= 8'h00;
		end else begin
			state_ff                <= nxt_state;
			receive_fault_tally_ff  <= nxt_rx[7:0];
			transmit_fault_tally_ff <= nxt_tx[8] ? 8'hff : nxt_tx[7:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seqCnt_ff     <= 8'h00;
			domCnt_ff     <= 5'h00;
			domAgain_ff   <= 1'b0;
			enable_ff     <= 1'b0;
		end else begin
			seqCnt_ff     <= nxt_seqCnt;
			domCnt_ff     <= nxt_domCnt;
			domAgain_ff   <= domRunAfterFlag && (domAgain_ff || domStep);
			enable_ff     <= enable;
		end
	end

	// flag polarity follows the state held while the error is seen, so the
	// error that makes the node passive still goes out dominant
	assign nodeState    = state_ff;
	assign busOn        = !(inSync || inOff);
	assign driverEn     = enable && !inOff && !inSync;
	assign dominantFlag = !passiveNow;
	assign fault_tally_register = {transmit_fault_tally_ff, receive_fault_tally_ff};
endmodule
`default_nettype wire

/* File: testbench/cfc_fault_confinement_properties.sv */
// cfc_fault_confinement_properties.sv: port checks of the fault confinement block.
// assumes: bound to cfc_fault_confinement, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module cfc_fault_confinement_properties
	import cfc_pkg::*;
#(
	parameter int SYNC_BITS = 11,
	parameter int OFF_SEQS  = 128
) (
	input wire logic          clk,                 // bit logic clock
	input wire logic          rstn,                // async reset, active low
	input wire logic          enable,              // module enable
	input wire logic          bitTick,             // bus bit strobe
	input wire logic          rxBit,               // bus level
	input wire cfc_state_type nodeState,           // node state
	input wire logic          busOn,               // taking part
	input wire logic          driverEn,            // driver enable
	input wire logic          dominantFlag,        // flag polarity
	input wire logic [15:0]   fault_tally_register // both tallies
);
	int         runCnt_ff;
	int         nxt_runCnt;
	int         offBits_ff;
	int         nxt_offBits;
	wire logic [7:0] txTally = fault_tally_register[15:8];
	wire logic [7:0] rxTally = fault_tally_register[7:0];
	// recessive run seen while waiting; any dominant bit restarts it
	assign nxt_runCnt = (nodeState != CFC_SYNC) ? 0 : !bitTick ? runCnt_ff : rxBit ? runCnt_ff + 1 : 0;
	// recessive bits seen while bus off, idle time included
	assign nxt_offBits = (nodeState != CFC_BUSOFF) ? 0 : (bitTick && rxBit) ? offBits_ff + 1 : offBits_ff;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			runCnt_ff  <= 0;
			offBits_ff <= 0;
		end else begin
			runCnt_ff  <= nxt_runCnt;
			offBits_ff <= nxt_offBits;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sync_wait_a: assert property (nodeState == CFC_ACTIVE && $past(nodeState) == CFC_SYNC |-> runCnt_ff >= SYNC_BITS)
		else $error("joined bus before the recessive run");
	active_drive_a: assert property (nodeState inside {CFC_ACTIVE, CFC_WARNING} && enable |->
		dominantFlag && driverEn && busOn)
		else $error("active node not driving dominant flags");
	active_level_a: assert property (nodeState == CFC_ACTIVE |-> txTally < 8'h60 && rxTally < 8'h60)
		else $error("plain active with a tally at warning level");
	warn_level_a: assert property (nodeState == CFC_WARNING |-> (txTally > 8'h5f || rxTally > 8'h5f) && !txTally[7] && !rxTally[7])
		else $error("warning state with tallies out of range");
	passive_level_a: assert property (nodeState == CFC_PASSIVE |-> txTally[7] || rxTally[7])
		else $error("passive with both tallies below 128");
	entry_flag_a: assert property ($rose(nodeState == CFC_PASSIVE) |-> $past(dominantFlag))
		else $error("entry error not flagged dominant");
	passive_flag_a: assert property (nodeState == CFC_PASSIVE && $past(nodeState) == CFC_PASSIVE |-> !dominantFlag)
		else $error("passive node flags dominant");
	off_entry_a: assert property ($rose(nodeState == CFC_BUSOFF) |-> $past(txTally) > 8'hf7)
		else $error("bus off with transmit tally too low");
	off_driver_a: assert property (nodeState == CFC_BUSOFF |-> !driverEn && !busOn)
		else $error("bus off node still drives");
	off_clear_a: assert property (nodeState == CFC_ACTIVE && $past(nodeState) == CFC_BUSOFF |-> fault_tally_register == 16'h0000)
		else $error("tallies not cleared after bus off");
	off_wait_a: assert property (nodeState == CFC_ACTIVE && $past(nodeState) == CFC_BUSOFF |->
		offBits_ff >= OFF_SEQS * SYNC_BITS)
		else $error("left bus off before the recessive runs");
	cover property ($rose(nodeState == CFC_WARNING));
	cover property ($rose(nodeState == CFC_PASSIVE));
	cover property ($fell(nodeState == CFC_BUSOFF));
endmodule
bind cfc_fault_confinement cfc_fault_confinement_properties #(.SYNC_BITS(SYNC_BITS), .OFF_SEQS(OFF_SEQS))
	u_cfc_fault_confinement_properties (.clk, .rstn, .enable, .bitTick, .rxBit, .nodeState, .busOn, .driverEn,
	.dominantFlag, .fault_tally_register);
`default_nettype wire

/* File: testbench/cfc_bus_node.sv */
// cfc_bus_node.sv: the other nodes on the bus, seen as sampled bits.
// assumes: one clock; four clocks per bus bit to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module cfc_bus_node (
	input  wire logic clk,     // bit logic clock
	input  wire logic rstn,    // async reset, active low
	input  wire logic dom,     // some node drives dominant
	output logic      bitTick, // one pulse per bus bit
	output logic      rxBit    // bus level, 1 recessive
);
	logic [1:0] phase_ff;
	logic [1:0] nxt_phase;
	// free-running bit phase
	assign nxt_phase = phase_ff + 2'h1;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) phase_ff <= 2'h0;
		else phase_ff <= nxt_phase;
	end
	// an undriven bus rests recessive, so idle time counts toward runs
	assign bitTick = (phase_ff == 2'h3);
	assign rxBit   = !dom;
endmodule
`default_nettype wire

/* File: testbench/tb_can_fault_confinement.sv */
// tb_can_fault_confinement.sv: self-checking bench of the fault confinement block.
// assumes: design and checker compiled first; bus bits come from cfc_bus_node.
`timescale 1ns/1ps
`default_nettype none
module tb_can_fault_confinement;
	import cfc_pkg::*;
	logic          clk = 0, rstn = 0, enable = 0, dom = 1, isTransmitter = 0;
	logic          txArbStuffErr = 0, txAckErr = 0, domInPassFlag = 0;
	logic          domRun = 0, flagPas = 0;
	logic [7:0]    pul = 8'h00;
	logic          bitTick, rxBit, busOn, driverEn, dominantFlag;
	logic [15:0]   fault_tally_register;
	logic [19:0]   q[$], want;
	cfc_state_type nodeState, st;
	int            rxRef = 0, txRef = 0, mismatches = 0, comparisons = 0, n;
	event          look;
	always #5 clk = ~clk;
	cfc_bus_node u_cfc_bus_node (.clk, .rstn, .dom, .bitTick, .rxBit);
	cfc_fault_confinement #(.SYNC_BITS(11), .OFF_SEQS(2)) u_cfc_fault_confinement (
		.clk, .rstn, .enable, .wakeUp(pul[7]), .bitTick, .rxBit,
		.rxFlagBitErr(pul[0]), .rxDomAfterFlag(pul[1]), .rxOtherErr(pul[2]),
		.txFlagBitErr(pul[3]), .txOtherErr(pul[4]), .txArbStuffErr, .txAckErr,
		.domInPassFlag, .domRunAfterFlag(domRun), .flagWasPassive(flagPas), .isTransmitter,
		.rxValid(pul[5]), .txValid(pul[6]), .nodeState, .busOn, .driverEn,
		.dominantFlag, .fault_tally_register);
	// note the expected outputs; the watcher compares once they have settled
	task automatic note();
		q.push_back({st, st != CFC_SYNC && st != CFC_BUSOFF, txRef > 255 ? 8'hff : txRef[7:0], rxRef[7:0]});
		-> look;
	endtask
	// one pulse of event k, then the reference tallies and state
	task automatic ev(input int k);
		@(negedge clk) pul[k] = 1'b1;
		@(negedge clk) pul[k] = 1'b0;
		if (k == 7) st = CFC_SYNC;
		else if (st != CFC_SYNC && st != CFC_BUSOFF) begin
			case (k)
				0, 1: rxRef = rxRef > 127 ? rxRef : rxRef + 8;
				2: rxRef = rxRef > 127 ? rxRef : rxRef + 1;
				3: txRef = txRef + 8;
				4: txRef = (txArbStuffErr || (st == CFC_PASSIVE && txAckErr && !domInPassFlag)) ? txRef : txRef + 8;
				5: rxRef = rxRef > 0 ? rxRef - 1 : 0;
				default: txRef = txRef > 0 ? txRef - 1 : 0;
			endcase
			st = txRef > 255 ? CFC_BUSOFF : (txRef > 127 || rxRef > 127) ? CFC_PASSIVE :
				(txRef > 95 || rxRef > 95) ? CFC_WARNING : CFC_ACTIVE;
		end
		note();
	endtask
	// dominant run after a flag held for a whole number of bits; the bit counts are
	// picked so that a step one bit early or late changes the tally
	task automatic dom_run(input logic passive, input int cycles, input int add);
		@(negedge clk) {dom, domRun, flagPas} = {2'b11, passive};
		repeat (cycles) @(negedge clk);
		{dom, domRun} = 2'b00;
		rxRef = rxRef + add;
		note();
	endtask
	// bounded wait for the join, far beyond the expected bit count
	task automatic join_bus();
		for (int i = 0; i < 400 && nodeState !== CFC_ACTIVE; i++) @(negedge clk);
		st = CFC_ACTIVE;
		note();
	endtask
	task automatic summarize();
		if (mismatches == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// take the oldest note whenever a settled result is announced
	// notes made in one time step share one wake-up, so drain them all
	always @(look) begin
		while (q.size() > 0) begin
			want = q.pop_front();
			comparisons++;
			if ({nodeState, driverEn, fault_tally_register} !== want) begin
				mismatches++;
				$display("wrong value at %0t: got %h want %h", $time, {nodeState, driverEn, fault_tally_register}, want);
			end
		end
	end
	// the run needs under 3000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		summarize();
	end
	initial begin
		n = $urandom(32'h429c);
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		st = CFC_SYNC;
		note();
		enable = 1'b1;
		repeat (40) @(negedge clk);
		dom = 1'b0;
		join_bus();
		dom_run(1'b0, 88, 16);
		dom_run(1'b1, 60, 8);
		n = $urandom_range(9, 1);
		repeat (n) ev(2);
		ev(0);
		ev(1);
		ev(5);
		while (rxRef < 128) ev(0);
		ev(2);
		while (rxRef > 90) ev(5);
		isTransmitter = 1'b1;
		ev(3);
		ev(6);
		txArbStuffErr = 1'b1;
		ev(4);
		txArbStuffErr = 1'b0;
		while (txRef < 128) ev(4);
		txAckErr = 1'b1;
		repeat (3) ev(4);
		domInPassFlag = 1'b1;
		while (txRef < 256) ev(4);
		ev(6);
		rxRef = 0;
		txRef = 0;
		join_bus();
		ev(7);
		join_bus();
		@(negedge clk);
		summarize();
	end
endmodule
`default_nettype wire
